//--- hdl/osc_stop_pkg.sv
/*
 package for the oscillation stop detector: register indices, field positions,
 reset values and state encodings.
 assumes an apb slave whose byte address is four times the register index.
*/
package osc_stop_pkg;

   localparam int ADDR_W = 22;
   localparam int CMP_W = 12;

   // register indices; byte address is index times four
   localparam logic [19:0] SUPPLY_OPT_IDX = 20'hf00f3;
   localparam logic [19:0] CLK_GATE_IDX = 20'hf00fc;
   localparam logic [19:0] RST_HOLD_IDX = 20'hf00fd;
   localparam logic [19:0] CTRL_IDX = 20'hf02d0;
   localparam logic [19:0] IRQ_STATUS_IDX = 20'hf02d1;
   localparam logic [19:0] IRQ_MASK_IDX = 20'hf02d2;

   // reset values
   localparam logic [7:0] BYTE_REG_RST = 8'h00;
   localparam logic [15:0] CTRL_RST = 16'h0fff;
   localparam logic [CMP_W-1:0] CMP_RST = 12'hfff;

   // field positions
   localparam int GATE_BIT = 6;
   localparam int SOFT_RST_BIT = 6;
   localparam int LOW_POWER_BIT = 7;
   localparam int TIMER_SEL_BIT = 4;
   localparam int RUN_BIT = 15;
   localparam int STOP_EVT_BIT = 0;

   // writable masks of the byte registers; other bits read as zero
   localparam logic [7:0] SUPPLY_OPT_MASK = 8'h90;
   localparam logic [7:0] CLK_GATE_MASK = 8'hf5;
   localparam logic [7:0] RST_HOLD_MASK = 8'hf4;

   typedef enum logic [1:0] {
      MON_IDLE = 2'b00,
      MON_WATCH = 2'b01,
      MON_TRIPPED = 2'b11
   } mon_state_t;

endpackage

//--- hdl/level_edge_if.sv
/*
 carrier between the detector core and its edge sensing stages.
 assumes the sampled level is synchronous to the owning clock.
*/
`timescale 1ns/10ps
interface level_edge_if;
   logic level;
   logic rise;
   modport sense (input level, output rise);
   modport user (output level, input rise);
endinterface

//--- hdl/edge_sense.sv
/*
 rising edge detector for a slow clock sampled on pclk.
 assumes the level is already synchronous to pclk.
*/
`timescale 1ns/10ps
module edge_sense
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // sampled level and its rising edge
   level_edge_if.sense edge_port
);
   logic last_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         last_reg <= 1'b0;
      else
         last_reg <= edge_port.level;
   end

   assign edge_port.rise = edge_port.level & ~last_reg;
endmodule

//--- hdl/osc_stop_detector.sv
/*
 oscillation stop detector with its gating, reset-hold and supply-option registers,
 apb register slave and level interrupt.
 assumes sub_clk_in and lowspeed_clk_in are levels synchronous to pclk,
 both much slower than pclk.
*/
// Behaviour
// RULE1 - count reference ticks while sub clock idle
// RULE2 - system reset leaves detection stopped
// RULE3 - stop on disable, pin or opcode reset
// RULE4 - judgment time is reference period times compare+1
// RULE5 - software sets gate bit before use
// RULE6 - gate off: control writes ignored, reads zero
// RULE7 - soft reset bit holds detector in reset
// RULE8 - system reset clears three byte registers
// RULE9 - software writes zero to gate bits 3,1
// RULE10 - low power cuts other peripherals' sub clock
// RULE11 - software keeps timer source select zero
// RULE12 - byte registers take bit and byte writes
// RULE13 - control sixteen bits, resets to 0fff
// RULE14 - stop declared within A-2 to A+1 cycles
// RULE15 - disable before compare change, never zero
// RULE16 - restart on sub edge, one pulse per stop
`timescale 1ns/10ps
module osc_stop_detector
#(
   parameter int AW = osc_stop_pkg::ADDR_W
)
(
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // monitored and reference clocks, sampled as levels
   input wire logic sub_clk_in,
   input wire logic lowspeed_clk_in,
   // system reset from the invalid opcode, one cycle pulse
   input wire logic opcode_reset,
   // cpu clock and standby state
   input wire logic cpu_on_subclock,
   input wire logic cpu_standby,
   // clock control outputs
   output logic others_subclk_stop,
   output logic timer_clock_source_select,
   // stop event pulse and level interrupt
   output logic osc_stop_pulse,
   output logic osc_stop_irq
);
   import osc_stop_pkg::*;

   logic [7:0] supply_opt_reg;
   logic [7:0] clk_gate_reg;
   logic [7:0] rst_hold_reg;
   logic detector_run_enable_reg;
   logic [CMP_W-1:0] judgment_compare_field_reg;
   logic irq_status_reg;
   logic irq_mask_reg;
   logic [CMP_W:0] idle_count_reg;
   mon_state_t mon_state_reg;
   logic [31:0] prdata_reg;
   logic slverr_reg;
   logic stop_pulse_reg;

   logic detector_clock_gate;
   logic detector_soft_reset;
   logic standby_subclock_cut;
   logic wr_access;
   logic rd_setup;
   logic [AW-1:0] a_supply;
   logic [AW-1:0] a_gate;
   logic [AW-1:0] a_hold;
   logic [AW-1:0] a_ctrl;
   logic [AW-1:0] a_stat;
   logic [AW-1:0] a_mask;
   logic hit_supply;
   logic hit_gate;
   logic hit_hold;
   logic hit_ctrl;
   logic hit_stat;
   logic hit_mask;
   logic hit_any;
   logic ctrl_wr_ok;
   logic sub_rise;
   logic ref_tick;
   logic stop_event;
   logic [31:0] rd_mux;

   level_edge_if sub_edge ();
   level_edge_if ref_edge ();

   assign sub_edge.level = sub_clk_in;
   assign ref_edge.level = lowspeed_clk_in;

   edge_sense sub_sense
   (
      .pclk(pclk),
      .presetn(presetn),
      .edge_port(sub_edge)
   );

   edge_sense ref_sense
   (
      .pclk(pclk),
      .presetn(presetn),
      .edge_port(ref_edge)
   );

   assign sub_rise = sub_edge.rise;
   assign ref_tick = ref_edge.rise;

   assign detector_clock_gate = clk_gate_reg[GATE_BIT];
   assign detector_soft_reset = rst_hold_reg[SOFT_RST_BIT];
   assign standby_subclock_cut = supply_opt_reg[LOW_POWER_BIT];

   // address decode; byte address is four times the index
   assign a_supply = AW'({SUPPLY_OPT_IDX, 2'b00});
   assign a_gate = AW'({CLK_GATE_IDX, 2'b00});
   assign a_hold = AW'({RST_HOLD_IDX, 2'b00});
   assign a_ctrl = AW'({CTRL_IDX, 2'b00});
   assign a_stat = AW'({IRQ_STATUS_IDX, 2'b00});
   assign a_mask = AW'({IRQ_MASK_IDX, 2'b00});

   assign hit_supply = (paddr == a_supply);
   assign hit_gate = (paddr == a_gate);
   assign hit_hold = (paddr == a_hold);
   assign hit_ctrl = (paddr == a_ctrl);
   assign hit_stat = (paddr == a_stat);
   assign hit_mask = (paddr == a_mask);
   assign hit_any = hit_supply | hit_gate | hit_hold | hit_ctrl | hit_stat | hit_mask;

   assign wr_access = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   // detector registers only writable with gate on and out of soft reset
   assign ctrl_wr_ok = detector_clock_gate & ~detector_soft_reset; // RULE6

   // system reset bytes; bit writes arrive as byte writes with masked bits
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         supply_opt_reg <= BYTE_REG_RST; // RULE8
      else if (opcode_reset)
         supply_opt_reg <= BYTE_REG_RST; // RULE8
      else if (wr_access && hit_supply && pstrb[0])
         supply_opt_reg <= pwdata[7:0] & SUPPLY_OPT_MASK; // RULE12
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         clk_gate_reg <= BYTE_REG_RST; // RULE8
      else if (opcode_reset)
         clk_gate_reg <= BYTE_REG_RST; // RULE8
      else if (wr_access && hit_gate && pstrb[0])
         clk_gate_reg <= pwdata[7:0] & CLK_GATE_MASK; // RULE12
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rst_hold_reg <= BYTE_REG_RST; // RULE8
      else if (opcode_reset)
         rst_hold_reg <= BYTE_REG_RST; // RULE8
      else if (wr_access && hit_hold && pstrb[0])
         rst_hold_reg <= pwdata[7:0] & RST_HOLD_MASK; // RULE12
   end

   // control register; gating off freezes contents without clearing them
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         detector_run_enable_reg <= 1'b0; // RULE2
         judgment_compare_field_reg <= CMP_RST; // RULE13
      end
      else if (opcode_reset || detector_soft_reset)
      begin
         detector_run_enable_reg <= 1'b0; // RULE3 RULE7
         judgment_compare_field_reg <= CMP_RST; // RULE7
      end
      else if (wr_access && hit_ctrl && ctrl_wr_ok)
      begin
         if (pstrb[1])
         begin
            detector_run_enable_reg <= pwdata[RUN_BIT]; // RULE3
            judgment_compare_field_reg[CMP_W-1:8] <= pwdata[CMP_W-1:8];
         end
         if (pstrb[0])
            judgment_compare_field_reg[7:0] <= pwdata[7:0];
      end
   end

   // idle counter: ticks of the reference since the last sub clock edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         idle_count_reg <= '0;
      else if (detector_soft_reset || !detector_run_enable_reg || sub_rise)
         idle_count_reg <= '0; // RULE16
      else if (ref_tick && detector_clock_gate && mon_state_reg == MON_WATCH)
         idle_count_reg <= idle_count_reg + 1'b1; // RULE1
   end

   // tick count reaching compare+1 is one judgment time
   assign stop_event = (mon_state_reg == MON_WATCH) && ref_tick && detector_clock_gate
      && (idle_count_reg == {1'b0, judgment_compare_field_reg}); // RULE4 RULE14

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mon_state_reg <= MON_IDLE;
      else if (detector_soft_reset || opcode_reset || !detector_run_enable_reg)
         mon_state_reg <= MON_IDLE; // RULE2 RULE3 RULE7
      else
      begin
         case (mon_state_reg)
            MON_IDLE:
               mon_state_reg <= MON_WATCH;
            MON_WATCH:
               if (stop_event)
                  mon_state_reg <= MON_TRIPPED; // RULE1
            MON_TRIPPED:
               // rearm only once the sub clock moves again
               if (sub_rise)
                  mon_state_reg <= MON_WATCH; // RULE16
            default:
               mon_state_reg <= MON_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         stop_pulse_reg <= 1'b0;
      else
         stop_pulse_reg <= stop_event; // RULE16
   end

   // sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_status_reg <= 1'b0;
      else if (detector_soft_reset || opcode_reset)
         irq_status_reg <= 1'b0;
      else if (stop_event)
         irq_status_reg <= 1'b1; // RULE1
      else if (wr_access && hit_stat && pstrb[0] && pwdata[STOP_EVT_BIT] && ctrl_wr_ok)
         irq_status_reg <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_mask_reg <= 1'b0;
      else if (detector_soft_reset || opcode_reset)
         irq_mask_reg <= 1'b0;
      else if (wr_access && hit_mask && pstrb[0] && ctrl_wr_ok)
         irq_mask_reg <= pwdata[STOP_EVT_BIT];
   end

   // read mux; detector registers read zero while gated off
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (hit_supply)
         rd_mux[7:0] = supply_opt_reg;
      else if (hit_gate)
         rd_mux[7:0] = clk_gate_reg;
      else if (hit_hold)
         rd_mux[7:0] = rst_hold_reg;
      else if (hit_ctrl && detector_clock_gate)
         rd_mux[15:0] = {detector_run_enable_reg, 3'b000, judgment_compare_field_reg}; // RULE6
      else if (hit_stat && detector_clock_gate)
         rd_mux[STOP_EVT_BIT] = irq_status_reg; // RULE6
      else if (hit_mask && detector_clock_gate)
         rd_mux[STOP_EVT_BIT] = irq_mask_reg; // RULE6
   end

   // read data captured in the setup cycle, ready in the access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_reg <= 32'h0000_0000;
      else if (rd_setup)
         prdata_reg <= rd_mux;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         slverr_reg <= 1'b0;
      else if (psel && !penable)
         slverr_reg <= ~hit_any;
   end

   assign prdata = prdata_reg;
   assign pready = 1'b1;
   assign pslverr = psel & penable & slverr_reg;

   // the detector stays on its own supply in low-power standby
   assign others_subclk_stop = standby_subclock_cut & cpu_on_subclock & cpu_standby; // RULE10
   assign timer_clock_source_select = supply_opt_reg[TIMER_SEL_BIT];

   assign osc_stop_pulse = stop_pulse_reg;
   assign osc_stop_irq = irq_status_reg & irq_mask_reg;
endmodule

//--- verification/osc_stop_monitor.sv
/*
 port assertions for the oscillation stop detector.
 assumes one pclk domain and reference ticks several pclk cycles apart.
*/
`timescale 1ns/10ps
module osc_stop_monitor
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pslverr,
   // clocks, resets and cpu state
   input wire logic sub_clk_in,
   input wire logic opcode_reset,
   input wire logic cpu_on_subclock,
   input wire logic cpu_standby,
   // outputs
   input wire logic others_subclk_stop,
   input wire logic timer_clock_source_select,
   input wire logic osc_stop_pulse,
   input wire logic osc_stop_irq
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence access_phase;
      psel && penable;
   endsequence
   sequence quiet_run;
      !osc_stop_pulse [*4];
   endsequence
   pulse_one_a: assert property (osc_stop_pulse |=> !osc_stop_pulse)
      else $error("stop pulse wider than one cycle");
   // margin of four cycles covers a stop pulse already registered when the edge comes; edge sensing itself adds no cycle
   rearm_quiet_a: assert property ($rose(sub_clk_in) |-> ##4 quiet_run)
      else $error("stop pulse right after a sub clock edge");
   reset_quiet_a: assert property ($rose(presetn) |-> !osc_stop_pulse [*8])
      else $error("detection running after reset");
   reset_clear_a: assert property ($rose(presetn) |->
      !osc_stop_irq && !timer_clock_source_select && !others_subclk_stop)
      else $error("outputs not cleared by reset");
   opcode_clear_a: assert property (opcode_reset |=>
      !osc_stop_irq && !timer_clock_source_select && !others_subclk_stop)
      else $error("opcode reset did not clear state");
   supply_cut_a: assert property (!(cpu_on_subclock && cpu_standby) |-> !others_subclk_stop)
      else $error("sub clock cut outside standby");
   select_hold_a: assert property (!(psel && penable && pwrite) && !opcode_reset
      |=> $stable(timer_clock_source_select))
      else $error("clock select changed without a write");
   irq_cause_a: assert property ($rose(osc_stop_irq) && !$past(psel && penable && pwrite)
      |-> ##[0:1] osc_stop_pulse)
      else $error("interrupt without a stop event");
   err_phase_a: assert property (pslverr |-> access_phase)
      else $error("error flag outside access phase");
endmodule
bind osc_stop_detector osc_stop_monitor chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pslverr(pslverr), .sub_clk_in(sub_clk_in),
   .opcode_reset(opcode_reset), .cpu_on_subclock(cpu_on_subclock), .cpu_standby(cpu_standby),
   .others_subclk_stop(others_subclk_stop), .osc_stop_pulse(osc_stop_pulse),
   .timer_clock_source_select(timer_clock_source_select), .osc_stop_irq(osc_stop_irq));

//--- verification/xtal_model.sv
/*
 crystal sub clock and low-speed reference clock, as pclk-synchronous levels.
 assumes pclk runs freely; both oscillators ignore chip reset.
*/
`timescale 1ns/10ps
module xtal_model
(
   // clock
   input wire logic pclk,
   // crystal running
   input wire logic run,
   // clock levels
   output logic sub_clk_in,
   output logic lowspeed_clk_in
);
   logic [2:0] phase_reg = 3'h0;
   logic sub_reg = 1'h0;
   always @(posedge pclk)
   begin
      phase_reg <= phase_reg + 3'h1;
      // a stopped crystal freezes at its last level
      if (run)
         sub_reg <= phase_reg[1];
   end
   assign sub_clk_in = sub_reg;
   assign lowspeed_clk_in = phase_reg[2];
endmodule

//--- verification/tb_oscillation_stop_detector.sv
/*
 self-checking bench for the oscillation stop detector.
 assumes the crystal model and the bound port monitor.
*/
`timescale 1ns/10ps
module tb_oscillation_stop_detector;
   import osc_stop_pkg::*;
   typedef struct {logic w; logic [19:0] i; logic [31:0] d; logic [31:0] x;} row_t;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic opcode_reset = 1'h0, cpu_on_subclock = 1'h0, cpu_standby = 1'h0, xtal_run = 1'h1;
   logic [21:0] paddr = 22'h0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, sub_clk_in, lowspeed_clk_in, others_subclk_stop;
   logic timer_clock_source_select, osc_stop_pulse, osc_stop_irq;
   int failures = 0, checked = 0, n;
   row_t rows [19] = '{'{1'h0, SUPPLY_OPT_IDX, 32'h0, 32'h0}, '{1'h0, CLK_GATE_IDX, 32'h0, 32'h0},
      '{1'h0, RST_HOLD_IDX, 32'h0, 32'h0}, '{1'h1, CTRL_IDX, 32'h5, 32'h0},
      '{1'h0, CTRL_IDX, 32'h0, 32'h0}, '{1'h1, CLK_GATE_IDX, 32'h40, 32'h0},
      '{1'h0, CTRL_IDX, 32'h0, 32'hfff}, '{1'h1, SUPPLY_OPT_IDX, 32'h90, 32'h0},
      '{1'h0, SUPPLY_OPT_IDX, 32'h0, 32'h90}, '{1'h1, CTRL_IDX, 32'h3, 32'h0},
      '{1'h1, CLK_GATE_IDX, 32'h0, 32'h0}, '{1'h0, CTRL_IDX, 32'h0, 32'h0},
      '{1'h1, CLK_GATE_IDX, 32'h40, 32'h0}, '{1'h0, CTRL_IDX, 32'h0, 32'h3},
      '{1'h1, RST_HOLD_IDX, 32'h40, 32'h0}, '{1'h0, CTRL_IDX, 32'h0, 32'hfff},
      '{1'h1, CTRL_IDX, 32'h5, 32'h0}, '{1'h0, CTRL_IDX, 32'h0, 32'hfff},
      '{1'h1, RST_HOLD_IDX, 32'h0, 32'h0}};
   osc_stop_detector dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sub_clk_in(sub_clk_in),
      .lowspeed_clk_in(lowspeed_clk_in), .opcode_reset(opcode_reset),
      .cpu_on_subclock(cpu_on_subclock), .cpu_standby(cpu_standby),
      .others_subclk_stop(others_subclk_stop), .osc_stop_pulse(osc_stop_pulse),
      .timer_clock_source_select(timer_clock_source_select), .osc_stop_irq(osc_stop_irq));
   xtal_model xtal_u (.pclk(pclk), .run(xtal_run), .sub_clk_in(sub_clk_in),
      .lowspeed_clk_in(lowspeed_clk_in));
   initial forever #2 pclk = ~pclk;
   task close_out;
      if (failures == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [19:0] i, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {i, 2'h0};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      // the wait for the answer ends once pready is high; the watchdog ends it if pready never comes
      do
         @(posedge pclk);
      while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // cycles to the next stop pulse, 300 when none comes
   task wait_pulse;
      n = 0;
      do
      begin
         @(negedge pclk);
         n++;
      end
      while (osc_stop_pulse !== 1'h1 && n < 300);
   endtask
   initial
   begin
      #40000;
      failures++;
      close_out();
   end
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      foreach (rows[r])
      begin
         apb(rows[r].w, rows[r].i, rows[r].d);
         if (!rows[r].w)
            chk(rd, rows[r].x);
      end
      apb(1'h0, 20'h00001, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      // lane 0 alone must leave run bit and compare bits 11:8 untouched
      pstrb <= 4'h1;
      apb(1'h1, CTRL_IDX, 32'h80aa);
      pstrb <= 4'hf;
      apb(1'h0, CTRL_IDX, 32'h0);
      chk(rd, 32'hfaa);
      chk(timer_clock_source_select, 32'h1);
      @(posedge pclk);
      cpu_on_subclock <= 1'h1;
      cpu_standby <= 1'h1;
      @(negedge pclk);
      chk(others_subclk_stop, 32'h1);
      @(posedge pclk);
      cpu_standby <= 1'h0;
      @(negedge pclk);
      chk(others_subclk_stop, 32'h0);
      for (int a = 3; a < 9; a += 3)
      begin
         apb(1'h1, IRQ_MASK_IDX, 32'(a == 3));
         apb(1'h1, CTRL_IDX, 32'(a));
         apb(1'h1, CTRL_IDX, 32'h8000 | 32'(a));
         wait_pulse;
         chk(n, 32'd300);
         @(posedge pclk);
         xtal_run <= 1'h0;
         wait_pulse;
         chk(n >= (a - 2) * 8 && n <= (a + 1) * 8 + 8, 32'h1);
         chk(osc_stop_irq, 32'(a == 3));
         wait_pulse;
         chk(n, 32'd300);
         apb(1'h0, IRQ_STATUS_IDX, 32'h0);
         chk(rd, 32'h1);
         apb(1'h1, IRQ_STATUS_IDX, 32'h1);
         apb(1'h0, IRQ_STATUS_IDX, 32'h0);
         chk({rd[30:0], osc_stop_irq}, 32'h0);
         apb(1'h1, CTRL_IDX, 32'(a));
         xtal_run <= 1'h1;
      end
      apb(1'h1, CTRL_IDX, 32'h8003);
      opcode_reset <= 1'h1;
      @(posedge pclk);
      opcode_reset <= 1'h0;
      xtal_run <= 1'h0;
      wait_pulse;
      chk(n, 32'd300);
      apb(1'h0, CLK_GATE_IDX, 32'h0);
      chk(rd, 32'h0);
      apb(1'h1, CLK_GATE_IDX, 32'h40);
      apb(1'h0, CTRL_IDX, 32'h0);
      chk(rd, 32'hfff);
      presetn <= 1'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, CLK_GATE_IDX, 32'h0);
      chk(rd, 32'h0);
      close_out();
   end
endmodule
